// >>> inc/dpmc_pkg.sv
// Purpose: Shared constants and types for the protection mode controller.
// Assumes: One system clock; no software bus into this block.
// Notes: State codes are one-hot.
package dpmc_pkg;
  localparam int ROWS_DEF = 16;
  localparam int ROW_IDX_W_DEF = 4;
  typedef enum logic [3:0] {
    DPMC_BOOT = 4'h1,
    DPMC_OPEN = 4'h2,
    DPMC_PROT = 4'h4,
    DPMC_KILL = 4'h8
  } dpmc_state_e;
  localparam logic [3:0] STATE_RST = 4'h1;
  localparam logic DEBUG_EN_RST = 1'b1;
  localparam logic ROW_PROT_RST = 1'b0;
endpackage

// >>> inc/dpmc_rowif.sv
// Purpose: Row protection request and answer bundle between modules.
// Assumes: Requests are single-cycle checks, answered combinationally.
// Notes: The modport names follow who asks.
interface dpmc_rowif #(parameter int IDX_W = 4);
  logic [IDX_W-1:0] idx;
  logic write_req;
  logic row_prot;
  logic write_ok;
  modport ctrl (output idx, output write_req, input row_prot, input write_ok);
  modport tbl (input idx, input write_req, output row_prot,
               output write_ok);
endinterface

// >>> core/dpmc_rows.sv
// Purpose: Per-row flash protection attribute table.
// Assumes: Attributes change only while a full erase completes.
// Notes: Storage is flip-flops indexed by row.
module dpmc_rows #(
  parameter int ROWS = dpmc_pkg::ROWS_DEF,
  parameter int IDX_W = dpmc_pkg::ROW_IDX_W_DEF
) (
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, high.
  input wire logic erase_done, // Full erase finishing pulse.
  input wire logic [ROWS-1:0] new_prot, // Levels loaded with the erase.
  dpmc_rowif.tbl rif // Row check port.
);
  logic [ROWS-1:0] prot_q;
  logic [ROWS-1:0] prot_d;

  genvar g;
  generate
    for (g = 0; g < ROWS; g++) begin : g_row
      always_comb begin
        prot_d[g] = erase_done ? new_prot[g] : prot_q[g]; // R15
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      prot_q <= {ROWS{dpmc_pkg::ROW_PROT_RST}};
    end else begin
      prot_q <= prot_d;
    end
  end

  always_comb begin
    rif.row_prot = prot_q[rif.idx]; // R14
    // Reads are always allowed; only writes to protected rows fail.
    rif.write_ok = rif.write_req & ~prot_q[rif.idx]; // R16 R17
  end
endmodule

// >>> core/dpmc_dbg.sv
// Purpose: Debug-port stall and access gating by protection state.
// Assumes: Debugger holds a request until it is accepted.
// Notes: Refused requests complete with an error flag.
module dpmc_dbg (
  input wire logic clk, // System clock.
  input wire logic rst, // Synchronous reset, high.
  input wire logic [3:0] state, // Current protection state.
  input wire logic loaded, // Protection state loaded.
  input wire logic dbg_en, // Firmware debug enable.
  input wire logic priv, // CPU privileged.
  input wire logic req, // Debug request.
  input wire logic is_user, // Targets user code or memory.
  input wire logic is_flash_ctl, // Targets flash control registers.
  input wire logic is_write, // Write request.
  output logic ack, // One-cycle completion.
  output logic err // Refusal, with ack.
);
  logic ack_q;
  logic ack_d;
  logic err_q;
  logic err_d;
  logic lock;

  always_comb begin
    lock = (state == dpmc_pkg::DPMC_PROT) || (state == dpmc_pkg::DPMC_KILL);
    ack_d = 1'b0;
    err_d = 1'b0;
    // Nothing is taken before the state is loaded, so the port stalls.
    if (req && loaded && !ack_q) begin // R5
      ack_d = 1'b1;
      if (!dbg_en) begin
        err_d = 1'b1; // R1 R2
      end else if (lock && is_user) begin
        err_d = 1'b1; // R9 R12
      end else if (lock && is_flash_ctl && is_write) begin
        err_d = 1'b1; // R10
      end else if (priv && (is_user || is_flash_ctl)) begin
        err_d = 1'b1; // R8
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
      err_q <= err_d;
    end
  end

  assign ack = ack_q;
  assign err = err_q;
endmodule

// >>> core/dpmc_top.sv
// Purpose: Device protection mode controller.
// Assumes: All inputs synchronous to SYS_CLK; 20 MHz clock.
// Notes: Firmware writes reach this block as a strobe with data.
// How it works
// R1 - Debug enabled after reset; firmware only disables.
// R2 - Debug returns only by erase and reprogram.
// R3 - Exactly one of four protection states.
// R4 - Reset enters BOOT until stored state loads.
// R5 - Debug port stalls until state loaded.
// R6 - BOOT forces CPU privileged.
// R7 - OPEN user mode permits programming and debug.
// R8 - Privileged OPEN restricts external and debug access.
// R9 - OPEN to PROTECTED accepted; user debug refused.
// R10 - Locked states block flash-control debug writes.
// R11 - PROTECTED to OPEN only after full erase.
// R12 - OPEN to KILL accepted; erase rejected.
// R13 - KILL never leaves.
// R14 - Each row protected or unprotected.
// R15 - Row attribute changes only with full erase.
// R16 - Unprotected rows allow all reads and writes.
// R17 - Protected rows refuse writes, allow reads.
// R18 - Firmware uses PROTECTED to block external reads.
// R19 - Privilege entered by held non-maskable interrupt.
// R20 - Unlisted transitions are ignored.
module dpmc_top #(
  parameter int ROWS = dpmc_pkg::ROWS_DEF,
  parameter int IDX_W = dpmc_pkg::ROW_IDX_W_DEF
) (
  input wire logic SYS_CLK, // System clock.
  input wire logic SYS_RST, // Synchronous reset, high.
  input wire logic LOAD_VALID, // Stored state from supervisor flash valid.
  input wire logic [3:0] LOAD_STATE, // Stored one-hot state.
  input wire logic WR_STB, // Firmware write of protection state.
  input wire logic [3:0] WR_STATE, // Requested one-hot state.
  input wire logic DBG_OFF_STB, // Firmware disables debug.
  input wire logic DBG_ON_STB, // New firmware re-enables debug.
  input wire logic NMI_IN, // Non-maskable interrupt held.
  input wire logic ERASE_REQ, // Full flash erase request.
  input wire logic ERASE_DONE, // Full flash erase finished.
  input wire logic [ROWS-1:0] NEW_ROW_PROT, // Row levels with erase.
  input wire logic ROW_REQ, // Row write check request.
  input wire logic [IDX_W-1:0] ROW_IDX, // Row index.
  input wire logic DBG_REQ, // Debug transaction request.
  input wire logic DBG_USER, // Targets user code or memory.
  input wire logic DBG_FLASH_CTL, // Targets flash control registers.
  input wire logic DBG_WRITE, // Debug write.
  output logic [3:0] PROT_STATE, // Protection state register.
  output logic CPU_PRIV, // CPU privileged.
  output logic DBG_ENABLED, // Debug circuitry enabled.
  output logic ERASE_GRANT, // Erase accepted, one cycle.
  output logic ERASE_REJECT, // Erase rejected, one cycle.
  output logic PROG_ALLOWED, // Flash programming permitted.
  output logic ROW_WRITE_OK, // Row write allowed.
  output logic ROW_PROTECTED, // Row is protected.
  output logic DBG_ACK, // Debug completion.
  output logic DBG_ERR // Debug refusal.
);
  dpmc_pkg::dpmc_state_e state_q;
  dpmc_pkg::dpmc_state_e state_d;
  logic loaded_q;
  logic loaded_d;
  logic erased_q;
  logic erased_d;
  logic dbg_en_q;
  logic dbg_en_d;
  logic priv_q;
  logic priv_d;
  logic grant_q;
  logic grant_d;
  logic reject_q;
  logic reject_d;
  logic prog_q;
  logic prog_d;
  logic wok_q;
  logic wok_d;
  logic rprot_q;
  logic rprot_d;
  logic row_done;

  dpmc_rowif #(.IDX_W(IDX_W)) rif ();

  assign rif.idx = ROW_IDX;
  assign rif.write_req = ROW_REQ;
  // Row levels change only on a completed erase that was not refused.
  assign row_done = ERASE_DONE && loaded_q &&
                    (state_q != dpmc_pkg::DPMC_KILL);

  dpmc_rows #(.ROWS(ROWS), .IDX_W(IDX_W)) u_rows (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .erase_done(row_done),
    .new_prot(NEW_ROW_PROT),
    .rif(rif.tbl)
  );

  always_comb begin
    state_d = state_q;
    loaded_d = loaded_q;
    erased_d = erased_q;
    if (!loaded_q) begin
      if (LOAD_VALID) begin // R4
        loaded_d = 1'b1;
        case (LOAD_STATE)
          dpmc_pkg::DPMC_OPEN: state_d = dpmc_pkg::DPMC_OPEN;
          dpmc_pkg::DPMC_PROT: state_d = dpmc_pkg::DPMC_PROT;
          dpmc_pkg::DPMC_KILL: state_d = dpmc_pkg::DPMC_KILL;
          default: state_d = dpmc_pkg::DPMC_OPEN;
        endcase
      end
    end else begin
      if (row_done) begin
        erased_d = 1'b1;
      end
      if (WR_STB) begin // R3 R20
        case (state_q)
          dpmc_pkg::DPMC_OPEN: begin
            if (WR_STATE == dpmc_pkg::DPMC_PROT) begin
              state_d = dpmc_pkg::DPMC_PROT; // R9
            end else if (WR_STATE == dpmc_pkg::DPMC_KILL) begin
              state_d = dpmc_pkg::DPMC_KILL; // R12
            end
          end
          dpmc_pkg::DPMC_PROT: begin
            if (WR_STATE == dpmc_pkg::DPMC_OPEN && (erased_q || row_done)) begin
              state_d = dpmc_pkg::DPMC_OPEN; // R11
              erased_d = 1'b0;
            end
          end
          default: state_d = state_q; // R13
        endcase
      end
    end
  end

  always_comb begin
    dbg_en_d = dbg_en_q;
    if (DBG_OFF_STB) begin
      dbg_en_d = 1'b0; // R1
    end else if (DBG_ON_STB && erased_q && state_q == dpmc_pkg::DPMC_OPEN) begin
      dbg_en_d = 1'b1; // R2
    end
    // BOOT forces privilege; later only a held NMI keeps it.
    priv_d = (state_d == dpmc_pkg::DPMC_BOOT) || NMI_IN; // R6 R19
    grant_d = 1'b0;
    reject_d = 1'b0;
    if (ERASE_REQ) begin
      if (state_q == dpmc_pkg::DPMC_KILL || !loaded_q) begin
        reject_d = 1'b1; // R12
      end else begin
        grant_d = 1'b1;
      end
    end
    prog_d = (state_d == dpmc_pkg::DPMC_OPEN) && !priv_d; // R7
    wok_d = rif.write_ok; // R16 R17
    rprot_d = rif.row_prot; // R14
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_q <= dpmc_pkg::DPMC_BOOT;
      loaded_q <= 1'b0;
      erased_q <= 1'b0;
      dbg_en_q <= dpmc_pkg::DEBUG_EN_RST;
      priv_q <= 1'b1;
      grant_q <= 1'b0;
      reject_q <= 1'b0;
      prog_q <= 1'b0;
      wok_q <= 1'b0;
      rprot_q <= 1'b0;
    end else begin
      state_q <= state_d;
      loaded_q <= loaded_d;
      erased_q <= erased_d;
      dbg_en_q <= dbg_en_d;
      priv_q <= priv_d;
      grant_q <= grant_d;
      reject_q <= reject_d;
      prog_q <= prog_d;
      wok_q <= wok_d;
      rprot_q <= rprot_d;
    end
  end

  dpmc_dbg u_dbg (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .state(state_q),
    .loaded(loaded_q),
    .dbg_en(dbg_en_q),
    .priv(priv_q),
    .req(DBG_REQ),
    .is_user(DBG_USER),
    .is_flash_ctl(DBG_FLASH_CTL),
    .is_write(DBG_WRITE),
    .ack(DBG_ACK),
    .err(DBG_ERR)
  );

  assign PROT_STATE = state_q;
  assign CPU_PRIV = priv_q;
  assign DBG_ENABLED = dbg_en_q;
  assign ERASE_GRANT = grant_q;
  assign ERASE_REJECT = reject_q;
  assign PROG_ALLOWED = prog_q;
  assign ROW_WRITE_OK = wok_q;
  assign ROW_PROTECTED = rprot_q;
endmodule

// >>> verification/dpmc_chk.sv
// Purpose: Port timing checks for the protection mode controller.
// Assumes: One clock domain with a synchronous high reset.
// Notes: A stored BOOT or unknown code comes up as OPEN.
module dpmc_chk (
  input wire logic SYS_CLK, // Clock.
  input wire logic SYS_RST, // Reset.
  input wire logic WR_STB, // Write strobe.
  input wire logic [3:0] WR_STATE, // Written state.
  input wire logic ERASE_REQ, // Erase request.
  input wire logic ROW_REQ, // Row check.
  input wire logic DBG_REQ, // Debug request.
  input wire logic DBG_USER, // User target.
  input wire logic DBG_FLASH_CTL, // Flash control target.
  input wire logic DBG_WRITE, // Debug write.
  input wire logic [3:0] PROT_STATE, // State.
  input wire logic CPU_PRIV, // Privileged.
  input wire logic ERASE_GRANT, // Erase granted.
  input wire logic ERASE_REJECT, // Erase rejected.
  input wire logic ROW_WRITE_OK, // Row writable.
  input wire logic ROW_PROTECTED, // Row protected.
  input wire logic DBG_ACK, // Debug done.
  input wire logic DBG_ERR // Debug refused.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  logic take;
  // A request is only taken when no answer stands in this cycle.
  assign take = DBG_REQ & !DBG_ACK & (PROT_STATE[2] | PROT_STATE[3]);
  property p_onehot; $onehot(PROT_STATE); endproperty
  a_onehot: assert property (p_onehot) else $error("State code bad.");
  property p_boot_priv; PROT_STATE == 4'h1 |-> CPU_PRIV; endproperty
  a_boot_priv: assert property (p_boot_priv) else $error("Boot user.");
  property p_stall; PROT_STATE == 4'h1 |-> !DBG_ACK; endproperty
  a_stall: assert property (p_stall) else $error("Debug in boot.");
  property p_kill; PROT_STATE == 4'h8 |=> PROT_STATE == 4'h8; endproperty
  a_kill: assert property (p_kill) else $error("Left kill.");
  property p_kill_erase;
    ERASE_REQ && PROT_STATE == 4'h8 |=> ERASE_REJECT && !ERASE_GRANT;
  endproperty
  a_kill_erase: assert property (p_kill_erase) else $error("Erase ok.");
  property p_ptok;
    WR_STB && WR_STATE == 4'h8 && PROT_STATE == 4'h4 |=> $stable(PROT_STATE);
  endproperty
  a_ptok: assert property (p_ptok) else $error("Bad move.");
  property p_row; ROW_REQ |=> ROW_WRITE_OK != ROW_PROTECTED; endproperty
  a_row: assert property (p_row) else $error("Row answer bad.");
  property p_user; take && DBG_USER |=> DBG_ACK && DBG_ERR; endproperty
  a_user: assert property (p_user) else $error("User debug ok.");
  property p_fctl;
    take && DBG_FLASH_CTL && DBG_WRITE |=> DBG_ACK && DBG_ERR;
  endproperty
  a_fctl: assert property (p_fctl) else $error("Flash write ok.");
  c_kill: cover property (PROT_STATE == 4'h8);
  c_err: cover property (DBG_ACK && DBG_ERR);
  c_grant: cover property (ERASE_GRANT);
endmodule
bind dpmc_top dpmc_chk i_dpmc_chk (.SYS_CLK, .SYS_RST, .WR_STB, .WR_STATE,
  .ERASE_REQ, .ROW_REQ, .DBG_REQ, .DBG_USER, .DBG_FLASH_CTL, .DBG_WRITE,
  .PROT_STATE, .CPU_PRIV, .ERASE_GRANT, .ERASE_REJECT, .ROW_WRITE_OK,
  .ROW_PROTECTED, .DBG_ACK, .DBG_ERR);

// >>> verification/dpmc_dbg_host.sv
// Purpose: External debugger model on the debug access port.
// Assumes: One transfer at a time, started by a one-cycle start.
// Notes: Attributes are inverted after each answer so stale values never help.
module dpmc_dbg_host (
  input wire logic clk, // System clock.
  input wire logic start, // Begin one transfer.
  input wire logic [2:0] kind, // User, flash control, write.
  input wire logic [3:0] lag, // Idle cycles before requesting.
  input wire logic DBG_ACK, // Completion.
  input wire logic DBG_ERR, // Refusal.
  output logic DBG_REQ = 1'b0, // Request.
  output logic DBG_USER = 1'b0, // User target.
  output logic DBG_FLASH_CTL = 1'b0, // Flash control target.
  output logic DBG_WRITE = 1'b0, // Write.
  output logic done = 1'b0, // Answer arrived.
  output logic got_err = 1'b0 // Answer was a refusal.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q = 4'h0;
  logic [2:0] kind_q = 3'h0;
  logic busy_q = 1'b0;
  always @(posedge clk) begin
    done <= 1'b0;
    if (start) begin
      busy_q <= 1'b1;
      wait_q <= lag;
      kind_q <= kind;
    end else if (busy_q && !DBG_REQ) begin
      if (wait_q == 4'h0) begin
        DBG_REQ <= 1'b1;
        {DBG_USER, DBG_FLASH_CTL, DBG_WRITE} <= kind_q;
      end else
        wait_q <= wait_q - 4'h1;
    end else if (DBG_REQ && DBG_ACK) begin
      DBG_REQ <= 1'b0;
      busy_q <= 1'b0;
      done <= 1'b1;
      got_err <= DBG_ERR;
      {DBG_USER, DBG_FLASH_CTL, DBG_WRITE} <= ~kind_q;
    end
  end
endmodule

// >>> verification/tb.sv
// Purpose: Self-checking bench for the protection mode controller.
// Assumes: Debug traffic comes from the debugger model only.
// Notes: A model tracks state, arming, privilege and row levels.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 1'b0, SYS_RST = 1'b1, LOAD_VALID = 1'b0, WR_STB = 1'b0;
  logic DBG_OFF_STB = 1'b0, DBG_ON_STB = 1'b0, NMI_IN = 1'b0, start = 1'b0;
  logic ERASE_REQ = 1'b0, ERASE_DONE = 1'b0, ROW_REQ = 1'b0;
  logic [3:0] LOAD_STATE = 4'h0, WR_STATE = 4'h0, ROW_IDX = 4'h0, lag = 4'h0;
  logic [15:0] NEW_ROW_PROT = 16'h0;
  logic [2:0] kind = 3'h0;
  logic [3:0] PROT_STATE, m_st;
  logic CPU_PRIV, DBG_ENABLED, ERASE_GRANT, ERASE_REJECT, PROG_ALLOWED;
  logic ROW_WRITE_OK, ROW_PROTECTED, DBG_ACK, DBG_ERR, DBG_REQ, DBG_USER;
  logic DBG_FLASH_CTL, DBG_WRITE, done, got_err, m_dbg, m_arm, m_nmi;
  logic [15:0] m_rows;
  int n_errors = 0, tests_run = 0;
  dpmc_top i_dpmc_top (.SYS_CLK, .SYS_RST, .LOAD_VALID, .LOAD_STATE, .WR_STB,
    .WR_STATE, .DBG_OFF_STB, .DBG_ON_STB, .NMI_IN, .ERASE_REQ, .ERASE_DONE,
    .NEW_ROW_PROT, .ROW_REQ, .ROW_IDX, .DBG_REQ, .DBG_USER, .DBG_FLASH_CTL,
    .DBG_WRITE, .PROT_STATE, .CPU_PRIV, .DBG_ENABLED, .ERASE_GRANT,
    .ERASE_REJECT, .PROG_ALLOWED, .ROW_WRITE_OK, .ROW_PROTECTED, .DBG_ACK,
    .DBG_ERR);
  dpmc_dbg_host i_dpmc_dbg_host (.clk(SYS_CLK), .start, .kind, .lag,
    .DBG_ACK, .DBG_ERR, .DBG_REQ, .DBG_USER, .DBG_FLASH_CTL, .DBG_WRITE,
    .done, .got_err);
  always #25 SYS_CLK = ~SYS_CLK;
  task automatic chk1(logic got, logic exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk4(logic [3:0] got, logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t state %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rst;
    @(posedge SYS_CLK);
    SYS_RST <= 1'b1;
    NMI_IN <= 1'b0;
    repeat (20) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    #1;
    {m_st, m_dbg, m_arm, m_nmi, m_rows} = {4'h1, 3'b100, 16'h0};
    chk4(PROT_STATE, 4'h1);
    chk1(CPU_PRIV, 1'b1);
    chk1(DBG_ENABLED, 1'b1);
  endtask
  task automatic load(logic [3:0] s);
    @(posedge SYS_CLK);
    LOAD_VALID <= 1'b1;
    LOAD_STATE <= s;
    @(posedge SYS_CLK);
    LOAD_VALID <= 1'b0;
    LOAD_STATE <= ~s;
    #1;
    m_st = (s == 4'h4 || s == 4'h8) ? s : 4'h2;
    chk4(PROT_STATE, m_st);
  endtask
  task automatic wr(logic [3:0] s);
    @(posedge SYS_CLK);
    WR_STB <= 1'b1;
    WR_STATE <= s;
    @(posedge SYS_CLK);
    WR_STB <= 1'b0;
    #1;
    if (m_st == 4'h2 && s[3:2] != 2'b00 && $onehot(s) ||
        m_st == 4'h4 && s == 4'h2 && m_arm)
      m_st = s;
  endtask
  task automatic erase(logic [15:0] rows);
    @(posedge SYS_CLK);
    ERASE_REQ <= 1'b1;
    @(posedge SYS_CLK);
    {ERASE_REQ, ERASE_DONE, NEW_ROW_PROT} <= {2'b01, rows};
    #1;
    chk1(ERASE_GRANT, m_st != 4'h8);
    chk1(ERASE_REJECT, m_st == 4'h8);
    @(posedge SYS_CLK);
    {ERASE_DONE, NEW_ROW_PROT} <= {1'b0, ~rows};
    if (m_st != 4'h8)
      {m_rows, m_arm} = {rows, 1'b1};
  endtask
  task automatic dbg(logic [2:0] k);
    int t;
    @(posedge SYS_CLK);
    {start, kind, lag} <= {1'b1, k, 4'($urandom_range(3))};
    @(posedge SYS_CLK);
    start <= 1'b0;
    for (t = 0; done !== 1'b1 && t < 40; t++)
      @(posedge SYS_CLK);
    #1;
    chk1(t < 40, 1'b1);
    chk1(got_err, !m_dbg || m_st[3:2] != 0 && (k[2] || k[1] && k[0]) ||
      m_nmi && k[2:1] != 0);
  endtask
  task automatic dbg_all;
    for (int k = 0; k < 8; k++)
      dbg(3'(k));
  endtask
  task automatic nmi(logic v);
    @(posedge SYS_CLK);
    NMI_IN <= v;
    m_nmi = v;
    repeat (2) @(posedge SYS_CLK);
    #1;
    chk1(CPU_PRIV, v);
    chk1(PROG_ALLOWED, !v);
  endtask
  task automatic stb(logic on, logic exp);
    @(posedge SYS_CLK);
    {DBG_ON_STB, DBG_OFF_STB} <= {on, !on};
    @(posedge SYS_CLK);
    {DBG_ON_STB, DBG_OFF_STB} <= 2'b00;
    @(posedge SYS_CLK);
    #1;
    m_dbg = exp;
    chk1(DBG_ENABLED, exp);
  endtask
  task automatic rows_chk;
    for (int i = 0; i < 16; i++) begin
      @(posedge SYS_CLK);
      {ROW_REQ, ROW_IDX} <= {1'b1, 4'(i)};
      @(posedge SYS_CLK);
      ROW_REQ <= 1'b0;
      #1;
      chk1(ROW_PROTECTED, m_rows[i]);
      chk1(ROW_WRITE_OK, !m_rows[i]);
    end
  endtask
  initial begin
    repeat (5000) @(posedge SYS_CLK);
    n_errors++;
    conclude();
  end
  initial begin
    void'($urandom(32'h35a0));
    rst();
    @(posedge SYS_CLK);
    start <= 1'b1;
    @(posedge SYS_CLK);
    start <= 1'b0;
    repeat (6) @(posedge SYS_CLK);
    #1;
    chk1(DBG_REQ && !done, 1'b1);
    load(4'h2);
    repeat (3) @(posedge SYS_CLK);
    chk1(DBG_REQ || got_err, 1'b0);
    dbg_all();
    nmi(1'b1);
    dbg_all();
    nmi(1'b0);
    stb(1'b0, 1'b0);
    dbg(3'h0);
    stb(1'b1, 1'b0);
    erase(16'($urandom));
    rows_chk();
    stb(1'b1, 1'b1);
    wr(4'h1);
    chk4(PROT_STATE, m_st);
    wr(4'h8);
    chk4(PROT_STATE, m_st);
    dbg_all();
    erase(16'($urandom));
    rows_chk();
    wr(4'h2);
    chk4(PROT_STATE, 4'h8);
    rst();
    load(4'h4);
    wr(4'h2);
    chk4(PROT_STATE, 4'h4);
    wr(4'h8);
    chk4(PROT_STATE, 4'h4);
    dbg_all();
    erase(16'($urandom));
    wr(4'h2);
    chk4(PROT_STATE, 4'h2);
    rst();
    load(4'h1);
    chk1(PROG_ALLOWED, 1'b1);
    wr(4'h4);
    chk4(PROT_STATE, 4'h4);
    chk1(PROG_ALLOWED, 1'b0);
    dbg_all();
    conclude();
  end
endmodule
